//--- src/test_control_regs.svh
// register offsets, field positions, reset values and timing counts of the test-control unit
// assumes byte addresses on a 32-bit avalon-mm slave, one aligned word per register
`ifndef TEST_CONTROL_REGS_SVH
`define TEST_CONTROL_REGS_SVH

`define TCTL_ADDR_DELAY     8'h00
`define TCTL_ADDR_TRIGGER   8'h04
`define TCTL_ADDR_EVT_ID    8'h08
`define TCTL_ADDR_EVT_TIME  8'h0c
`define TCTL_ADDR_FORMAT    8'h10
`define TCTL_ADDR_CAPS      8'h14
`define TCTL_ADDR_TIMEOUT   8'h18

`define TCTL_TRIG_BIT       0
`define TCTL_FMT_LSB        0
`define TCTL_FMT_MSB        1
`define TCTL_PATTERN_BIT    8

`define TCTL_DELAY_RST      32'h0000_0000
`define TCTL_TIMEOUT_RST_MS 32'h0000_00c8
// arbitrary value
`define TCTL_EVT_ID_VALUE   32'h0000_5e57

`define TCTL_MS_NS          1000000
`define TCTL_CLK_NS         20

`endif

//--- src/test_control_pkg.sv
// types shared by the test-control unit
// assumes test_control_regs.svh carries every number
package test_control_pkg;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_DELAY = 3'b010,
		ST_RESP  = 3'b100
	} bus_state_t;

	typedef enum logic [1:0] {
		FMT_OFF       = 2'h0,
		FMT_MULTI     = 2'h1,
		FMT_CONTAINER = 2'h2
	} payload_fmt_t;

endpackage : test_control_pkg

//--- src/two_entry_buffer.sv
// two-entry buffer with valid/ready on both sides
// assumes one clock, asynchronous active-high reset
module two_entry_buffer #(
	parameter int W = 64
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_valid,
	output logic              o_ready,
	input  wire logic [W-1:0] i_data,
	output logic              o_valid,
	input  wire logic         i_ready,
	output logic [W-1:0]      o_data
);

	logic [W-1:0] mem_r [2];
	logic [W-1:0] mem_nxt [2];
	logic         wr_ptr_r;
	logic         wr_ptr_nxt;
	logic         rd_ptr_r;
	logic         rd_ptr_nxt;
	logic [1:0]   count_r;
	logic [1:0]   count_nxt;
	logic         push;
	logic         pop;

	////////////////////////////////////////////////////////////////////////////////
	assign o_ready = (count_r != 2'h2);
	assign o_valid = (count_r != 2'h0);
	assign o_data  = mem_r[rd_ptr_r];

	always_comb begin
		push       = i_valid && o_ready;
		pop        = o_valid && i_ready;
		mem_nxt    = mem_r;
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		count_nxt  = count_r;
		if (push) begin
			mem_nxt[wr_ptr_r] = i_data;
			wr_ptr_nxt        = ~wr_ptr_r;
		end
		if (pop) begin
			rd_ptr_nxt = ~rd_ptr_r;
		end
		if (push && !pop) begin
			count_nxt = count_r + 2'h1;
		end else if (pop && !push) begin
			count_nxt = count_r - 2'h1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int k = 0; k < 2; k++) begin
				mem_r[k] <= '0;
			end
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r  <= 2'h0;
		end else begin
			mem_r    <= mem_nxt;
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r  <= count_nxt;
		end
	end

endmodule : two_entry_buffer

//--- src/test_control_features.sv
// test-control unit: delayed write acknowledge, test event source, payload test format
// assumes capability and negotiation inputs come from logic on i_clk; the event sink may stall
//
// Operation
// RQ1 - a write to the delay value stalls its acknowledge for that many milliseconds
// RQ2 - if the delay exceeds the response timeout, pending acknowledges go out meanwhile
// RQ3 - reading the delay value answers at once with the stored value
// RQ4 - a trigger command emits exactly one test event
// RQ5 - test events are always enabled, no enable or selection gates them
// RQ6 - each event carries an identifier and a timestamp, both readable by software
// RQ7 - format off means no test effect, streaming follows normal configuration
// RQ8 - the format selection comes up off after every reset
// RQ9 - multi-section mode streams every payload multi-section, at least one section
// RQ10 - multi-section option offered exactly when the device supports it
// RQ11 - multi-section mode refused unless negotiation admitted it
// RQ12 - container mode streams every payload as container, at least one component
// RQ13 - container option offered whenever the device supports the container format
// RQ14 - container mode refused unless negotiation admitted it
// RQ15 - in test mode the content may be real image data or a pattern
// RQ16 - delay timed by a millisecond tick from the clock, pendings spaced inside timeout
//
// Our own choices: the Avalon-MM slave port and the register addresses.
`include "test_control_regs.svh"

module test_control_features #(
	parameter int          CYC_PER_MS  = `TCTL_MS_NS / `TCTL_CLK_NS,
	parameter logic [31:0] TIMEOUT_RST = `TCTL_TIMEOUT_RST_MS
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [3:0]  i_byteenable,
	input  wire logic [31:0] i_writedata,
	output logic [31:0]      o_readdata,
	output logic             o_waitrequest,
	output logic             o_pending_ack,
	output logic             o_ack_long_wait,
	output logic             o_evt_valid,
	input  wire logic        i_evt_ready,
	output logic [31:0]      o_evt_id,
	output logic [31:0]      o_evt_time,
	input  wire logic        i_multi_supported,
	input  wire logic        i_multi_negotiated,
	input  wire logic        i_container_supported,
	input  wire logic        i_container_negotiated,
	output logic             o_fmt_multi_section,
	output logic             o_fmt_container,
	output logic             o_test_pattern
);

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [31:0] TICK_LAST = 32'(CYC_PER_MS - 1);

	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  be
	);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	function automatic logic fmt_allowed(
		input logic [1:0] f,
		input logic       m_sup,
		input logic       m_neg,
		input logic       c_sup,
		input logic       c_neg
	);
		logic ok;
		ok = 1'b0;
		case (f)
			test_control_pkg::FMT_OFF: begin
				ok = 1'b1;
			end
			test_control_pkg::FMT_MULTI: begin
				ok = m_sup && m_neg; // RQ11
			end
			test_control_pkg::FMT_CONTAINER: begin
				ok = c_sup && c_neg; // RQ14
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction : fmt_allowed

	////////////////////////////////////////////////////////////////////////////////
	test_control_pkg::bus_state_t   state_r;
	test_control_pkg::bus_state_t   state_nxt;
	test_control_pkg::payload_fmt_t fmt_r;
	test_control_pkg::payload_fmt_t fmt_nxt;
	logic [31:0] delay_r;
	logic [31:0] delay_nxt;
	logic [31:0] timeout_r;
	logic [31:0] timeout_nxt;
	logic [31:0] ms_left_r;
	logic [31:0] ms_left_nxt;
	logic [31:0] tick_cnt_r;
	logic [31:0] tick_cnt_nxt;
	logic [31:0] pend_cnt_r;
	logic [31:0] pend_cnt_nxt;
	logic        long_r;
	logic        long_nxt;
	logic        pend_r;
	logic        pend_nxt;
	logic        pattern_r;
	logic        pattern_nxt;
	logic [31:0] evt_id_r;
	logic [31:0] evt_id_nxt;
	logic [31:0] evt_time_r;
	logic [31:0] evt_time_nxt;
	logic [31:0] stamp_r;
	logic [31:0] stamp_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic        wait_c;
	logic        tick;
	logic        evt_push;
	logic        evt_ready;
	logic [31:0] merged;
	logic [31:0] pend_ivl;
	logic [63:0] evt_out;

	////////////////////////////////////////////////////////////////////////////////
	// pendings every half timeout, every millisecond below a 2 ms timeout, so from 2 ms up each lands well inside the host's response window
	assign pend_ivl = (timeout_r[31:1] == 31'h0) ? 32'h0000_0001 : {1'b0, timeout_r[31:1]}; // RQ16
	assign tick     = (tick_cnt_r == TICK_LAST); // RQ16
	assign merged   = merge_bytes(32'h0000_0000, i_writedata, i_byteenable);

	always_comb begin
		state_nxt    = state_r;
		fmt_nxt      = fmt_r;
		delay_nxt    = delay_r;
		timeout_nxt  = timeout_r;
		ms_left_nxt  = ms_left_r;
		tick_cnt_nxt = tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001; // RQ16
		pend_cnt_nxt = pend_cnt_r;
		long_nxt     = long_r;
		pend_nxt     = 1'b0;
		pattern_nxt  = pattern_r;
		evt_id_nxt   = evt_id_r;
		evt_time_nxt = evt_time_r;
		stamp_nxt    = stamp_r + 32'h0000_0001;
		rdata_nxt    = rdata_r;
		wait_c       = 1'b1;
		evt_push     = 1'b0;
		case (state_r)
			test_control_pkg::ST_IDLE: begin
				wait_c = 1'b0;
				if (i_read) begin
					wait_c    = 1'b1;
					state_nxt = test_control_pkg::ST_RESP;
					case (i_address)
						`TCTL_ADDR_DELAY: begin
							rdata_nxt = delay_r; // RQ3
						end
						`TCTL_ADDR_EVT_ID: begin
							rdata_nxt = evt_id_r; // RQ6
						end
						`TCTL_ADDR_EVT_TIME: begin
							rdata_nxt = evt_time_r; // RQ6
						end
						`TCTL_ADDR_FORMAT: begin
							rdata_nxt = {23'h0, pattern_r, 6'h0, fmt_r};
						end
						`TCTL_ADDR_CAPS: begin
							// option bits follow support alone; negotiation shown beside them
							rdata_nxt = {28'h0, i_container_negotiated, i_multi_negotiated,
								i_container_supported, i_multi_supported}; // RQ10 RQ13
						end
						`TCTL_ADDR_TIMEOUT: begin
							rdata_nxt = timeout_r;
						end
						default: begin
							rdata_nxt = 32'h0000_0000;
						end
					endcase
				end else if (i_write) begin
					case (i_address)
						`TCTL_ADDR_DELAY: begin
							wait_c       = 1'b1; // RQ1
							delay_nxt    = merge_bytes(delay_r, i_writedata, i_byteenable);
							ms_left_nxt  = merge_bytes(delay_r, i_writedata, i_byteenable);
							long_nxt     = merge_bytes(delay_r, i_writedata, i_byteenable) > timeout_r; // RQ2
							tick_cnt_nxt = 32'h0000_0000; // RQ16
							pend_cnt_nxt = 32'h0000_0000;
							state_nxt    = test_control_pkg::ST_DELAY;
						end
						`TCTL_ADDR_TRIGGER: begin
							// no enable or selection stands in the way of a test event
							if (merged[`TCTL_TRIG_BIT]) begin // RQ5
								if (!evt_ready) begin
									wait_c = 1'b1;
								end else begin
									evt_push     = 1'b1; // RQ4
									evt_id_nxt   = `TCTL_EVT_ID_VALUE; // RQ6
									evt_time_nxt = stamp_r; // RQ6
								end
							end
						end
						`TCTL_ADDR_FORMAT: begin
							if (i_byteenable[0] && fmt_allowed(i_writedata[`TCTL_FMT_MSB:`TCTL_FMT_LSB],
								i_multi_supported, i_multi_negotiated,
								i_container_supported, i_container_negotiated)) begin // RQ11 RQ14
								fmt_nxt = test_control_pkg::payload_fmt_t'(
									i_writedata[`TCTL_FMT_MSB:`TCTL_FMT_LSB]);
							end
							if (i_byteenable[1]) begin
								pattern_nxt = i_writedata[`TCTL_PATTERN_BIT]; // RQ15
							end
						end
						`TCTL_ADDR_TIMEOUT: begin
							timeout_nxt = merge_bytes(timeout_r, i_writedata, i_byteenable);
						end
						default: begin
							wait_c = 1'b0;
						end
					endcase
				end
			end
			test_control_pkg::ST_DELAY: begin
				wait_c = 1'b1; // RQ1
				if (ms_left_r == 32'h0000_0000) begin
					state_nxt = test_control_pkg::ST_RESP;
				end else if (tick) begin
					ms_left_nxt = ms_left_r - 32'h0000_0001; // RQ1
					if (long_r) begin
						if (pend_cnt_r + 32'h0000_0001 >= pend_ivl) begin
							pend_nxt     = 1'b1; // RQ2
							pend_cnt_nxt = 32'h0000_0000;
						end else begin
							pend_cnt_nxt = pend_cnt_r + 32'h0000_0001;
						end
					end
				end
			end
			test_control_pkg::ST_RESP: begin
				wait_c    = 1'b0;
				state_nxt = test_control_pkg::ST_IDLE;
			end
			default: begin
				wait_c    = 1'b0;
				state_nxt = test_control_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r    <= test_control_pkg::ST_IDLE;
			fmt_r      <= test_control_pkg::FMT_OFF; // RQ8
			delay_r    <= `TCTL_DELAY_RST;
			timeout_r  <= TIMEOUT_RST;
			ms_left_r  <= 32'h0000_0000;
			tick_cnt_r <= 32'h0000_0000;
			pend_cnt_r <= 32'h0000_0000;
			long_r     <= 1'b0;
			pend_r     <= 1'b0;
			pattern_r  <= 1'b0;
			evt_id_r   <= 32'h0000_0000;
			evt_time_r <= 32'h0000_0000;
			stamp_r    <= 32'h0000_0000;
			rdata_r    <= 32'h0000_0000;
		end else begin
			state_r    <= state_nxt;
			fmt_r      <= fmt_nxt;
			delay_r    <= delay_nxt;
			timeout_r  <= timeout_nxt;
			ms_left_r  <= ms_left_nxt;
			tick_cnt_r <= tick_cnt_nxt;
			pend_cnt_r <= pend_cnt_nxt;
			long_r     <= long_nxt;
			pend_r     <= pend_nxt;
			pattern_r  <= pattern_nxt;
			evt_id_r   <= evt_id_nxt;
			evt_time_r <= evt_time_nxt;
			stamp_r    <= stamp_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// a stalled event sink fills the two-entry buffer, then holds the trigger write, so no event word is dropped
	two_entry_buffer #(
		.W (64)
	) u_evt_buf (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_valid (evt_push),
		.o_ready (evt_ready),
		.i_data  ({`TCTL_EVT_ID_VALUE, stamp_r}),
		.o_valid (o_evt_valid),
		.i_ready (i_evt_ready),
		.o_data  (evt_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	assign o_evt_id            = evt_out[63:32];
	assign o_evt_time          = evt_out[31:0];
	assign o_readdata          = rdata_r;
	assign o_waitrequest       = wait_c;
	assign o_pending_ack       = pend_r; // RQ2
	assign o_ack_long_wait     = long_r && (state_r == test_control_pkg::ST_DELAY); // RQ2
	// off leaves both format outputs low, so the stream path runs its normal setup
	assign o_fmt_multi_section = (fmt_r == test_control_pkg::FMT_MULTI); // RQ7 RQ9
	assign o_fmt_container     = (fmt_r == test_control_pkg::FMT_CONTAINER); // RQ7 RQ12
	assign o_test_pattern      = pattern_r && (fmt_r != test_control_pkg::FMT_OFF); // RQ15

endmodule : test_control_features

//--- sim/evt_sink_model.sv
// event sink on the far side of the test event stream
// assumes one clock; i_stall holds ready low so the unit must buffer
module evt_sink_model (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_valid,
	input  wire logic        i_stall,
	input  wire logic [31:0] i_id,
	input  wire logic [31:0] i_time,
	output logic             o_ready,
	output int               o_count,
	output logic [31:0]      o_last_id,
	output logic [31:0]      o_first_time,
	output logic [31:0]      o_last_time
);
	timeunit 1ns;
	timeprecision 1ns;
	assign o_ready = !i_stall;
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_count <= 0;
		end else if (i_valid && o_ready) begin
			o_count <= o_count + 1;
			o_last_id <= i_id;
			o_last_time <= i_time;
			if (o_count == 0) o_first_time <= i_time;
		end
	end
endmodule : evt_sink_model

//--- sim/test_control_features_props.sv
// port checker of the test-control unit
// assumes bound into test_control_features, one clock domain
`include "test_control_regs.svh"
module test_control_features_props #(
	parameter int CYC_PER_MS = 50000
) (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic [7:0]  i_address,
	input wire logic        i_read,
	input wire logic        i_write,
	input wire logic [3:0]  i_byteenable,
	input wire logic [31:0] i_writedata,
	input wire logic        o_waitrequest,
	input wire logic        o_pending_ack,
	input wire logic        o_ack_long_wait,
	input wire logic        o_evt_valid,
	input wire logic        i_evt_ready,
	input wire logic [31:0] o_evt_id,
	input wire logic [31:0] o_evt_time,
	input wire logic        i_multi_supported,
	input wire logic        i_multi_negotiated,
	input wire logic        i_container_supported,
	input wire logic        i_container_negotiated,
	input wire logic        o_fmt_multi_section,
	input wire logic        o_fmt_container
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic [31:0] wcnt_r;
	logic [31:0] wcnt_nxt;
	logic [31:0] dly_cyc;
	// stalled write cycles; a range of two absorbs the accepting idle cycle and the zero-check cycle
	always_comb wcnt_nxt = (i_write && o_waitrequest) ? wcnt_r + 32'h1 : 32'h0;
	always_comb dly_cyc = 32'(i_writedata * CYC_PER_MS);
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) wcnt_r <= 32'h0;
		else wcnt_r <= wcnt_nxt;
	end
	////////////////////////////////////////////////////////////////
	a_delay_span: assert property (i_write && !o_waitrequest && i_address == `TCTL_ADDR_DELAY &&
		i_byteenable == 4'hf |-> wcnt_r >= dly_cyc && wcnt_r <= dly_cyc + 32'h2)
		else $error("delay write stall length wrong");
	a_pend_in_long: assert property (o_pending_ack |-> o_ack_long_wait && i_write && o_waitrequest)
		else $error("pending ack outside a long write");
	a_read_one_wait: assert property ($rose(i_read) |-> o_waitrequest ##1 !o_waitrequest)
		else $error("read not answered after one wait");
	a_trig_event: assert property (i_write && !o_waitrequest && i_address == `TCTL_ADDR_TRIGGER
		&& i_writedata[0] |=> o_evt_valid) else $error("trigger gave no event");
	a_evt_hold: assert property (o_evt_valid && !i_evt_ready |=> o_evt_valid
		&& $stable(o_evt_time)) else $error("stalled event lost");
	a_evt_ident: assert property (o_evt_valid |-> o_evt_id == `TCTL_EVT_ID_VALUE)
		else $error("event identifier wrong");
	a_fmt_boot_off: assert property ($fell(i_rst) |-> !o_fmt_multi_section && !o_fmt_container)
		else $error("format not off after reset");
	a_multi_admit: assert property ($rose(o_fmt_multi_section)
		|-> $past(i_multi_supported && i_multi_negotiated)) else $error("multi mode not admitted");
	a_cont_admit: assert property ($rose(o_fmt_container)
		|-> $past(i_container_supported && i_container_negotiated)) else $error("container not admitted");
	a_fmt_single: assert property (!(o_fmt_multi_section && o_fmt_container))
		else $error("two payload formats at once");
	c_pending: cover property (o_pending_ack);
	c_evt_stall: cover property (o_evt_valid && !i_evt_ready);
	c_container: cover property (o_fmt_container);
endmodule : test_control_features_props
bind test_control_features test_control_features_props #(.CYC_PER_MS(CYC_PER_MS)) u_props (
	.i_clk                  (i_clk),
	.i_rst                  (i_rst),
	.i_address              (i_address),
	.i_read                 (i_read),
	.i_write                (i_write),
	.i_byteenable           (i_byteenable),
	.i_writedata            (i_writedata),
	.o_waitrequest          (o_waitrequest),
	.o_pending_ack          (o_pending_ack),
	.o_ack_long_wait        (o_ack_long_wait),
	.o_evt_valid            (o_evt_valid),
	.i_evt_ready            (i_evt_ready),
	.o_evt_id               (o_evt_id),
	.o_evt_time             (o_evt_time),
	.i_multi_supported      (i_multi_supported),
	.i_multi_negotiated     (i_multi_negotiated),
	.i_container_supported  (i_container_supported),
	.i_container_negotiated (i_container_negotiated),
	.o_fmt_multi_section    (o_fmt_multi_section),
	.o_fmt_container        (o_fmt_container)
);

//--- sim/test_control_features_tb.sv
// self-checking bench of the test-control unit
// assumes a short millisecond (8 cycles) and an event sink model
module test_control_features_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] f;} row_t;
	// {multi, container} expected after each row; all capabilities admitted
	row_t rows [8] = '{{8'h18, 32'h2, 32'h2, 2'h0}, {8'h00, 32'h3, 32'h3, 2'h0},
		{8'h10, 32'h1, 32'h1, 2'h2}, {8'h10, 32'h3, 32'h1, 2'h2}, {8'h10, 32'h2, 32'h2, 2'h1},
		{8'h10, 32'h0, 32'h0, 2'h0}, {8'h20, 32'h5, 32'h0, 2'h0}, {8'h14, 32'h0, 32'hf, 2'h0}};
	logic i_clk = 0, i_rst = 1, i_read = 0, i_write = 0, ms = 1, mn = 1, cs = 1, cn = 1, stall = 0;
	logic [7:0]  i_address = 8'h00;
	logic [31:0] i_writedata = 32'h0, rd, id, tm, lid, t0, t1;
	logic o_wr, o_pa, o_lw, o_ev, rdy, o_m, o_c, o_p;
	logic [31:0] o_rd;
	int n_mismatch = 0, num_checks = 0, cyc = 0, npend = 0, nlong = 0, p0, l0, cnt;
	test_control_features #(.CYC_PER_MS(8)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_byteenable(4'hf), .i_writedata(i_writedata),
		.o_readdata(o_rd), .o_waitrequest(o_wr), .o_pending_ack(o_pa), .o_ack_long_wait(o_lw),
		.o_evt_valid(o_ev), .i_evt_ready(rdy), .o_evt_id(id), .o_evt_time(tm),
		.i_multi_supported(ms), .i_multi_negotiated(mn), .i_container_supported(cs),
		.i_container_negotiated(cn), .o_fmt_multi_section(o_m), .o_fmt_container(o_c), .o_test_pattern(o_p));
	evt_sink_model sink (.i_clk(i_clk), .i_rst(i_rst), .i_valid(o_ev), .i_stall(stall), .i_id(id),
		.i_time(tm), .o_ready(rdy), .o_count(cnt), .o_last_id(lid), .o_first_time(t0), .o_last_time(t1));
	always #10 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (o_pa === 1'b1) npend <= npend + 1;
		if (o_lw === 1'b1) nlong <= nlong + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// requests held until waitrequest is seen low, then one idle edge
	task bw(input logic [7:0] a, input logic [31:0] d);
		i_address <= a;
		i_writedata <= d;
		i_write <= 1'b1;
		@(posedge i_clk);
		while (o_wr !== 1'b0) @(posedge i_clk);
		i_write <= 1'b0;
		@(posedge i_clk);
	endtask : bw
	task br(input logic [7:0] a);
		i_address <= a;
		i_read <= 1'b1;
		@(posedge i_clk);
		while (o_wr !== 1'b0) @(posedge i_clk);
		rd = o_rd;
		i_read <= 1'b0;
		@(posedge i_clk);
	endtask : br
	task stop_test();
		if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		foreach (rows[i]) begin
			bw(rows[i].a, rows[i].d);
			br(rows[i].a);
			chk(rd, rows[i].e);
			chk({30'h0, o_m, o_c}, {30'h0, rows[i].f});
		end
		bw(8'h10, 32'h1);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		br(8'h10);
		chk(rd, 32'h0);
		br(8'h18);
		chk(rd, 32'hc8);
		mn <= 1'b0;
		cn <= 1'b0;
		bw(8'h10, 32'h1);
		bw(8'h10, 32'h2);
		br(8'h10);
		chk(rd, 32'h0);
		// pattern alone does nothing while the format is off
		bw(8'h10, 32'h100);
		chk({31'h0, o_p}, 32'h0);
		mn <= 1'b1;
		bw(8'h10, 32'h101);
		chk({31'h0, o_p}, 32'h1);
		bw(8'h18, 32'h2);
		// timeout 2 ms: a pending on every tick, long wait over 5*8+1 delay cycles
		p0 = npend;
		l0 = nlong;
		bw(8'h00, 32'h5);
		chk(npend - p0, 32'h5);
		chk(nlong - l0, 32'h29);
		p0 = npend;
		l0 = nlong;
		bw(8'h00, 32'h1);
		chk(npend - p0, 32'h0);
		chk(nlong - l0, 32'h0);
		stall <= 1'b1;
		bw(8'h04, 32'h1);
		bw(8'h04, 32'h1);
		fork
			bw(8'h04, 32'h1);
			begin
				repeat (6) @(posedge i_clk);
				chk({31'h0, o_wr}, 32'h1);
				stall <= 1'b0;
			end
		join
		repeat (4) @(posedge i_clk);
		chk(cnt, 32'h3);
		chk(lid, `TCTL_EVT_ID_VALUE);
		chk({31'h0, t1 > t0}, 32'h1);
		br(8'h08);
		chk(rd, `TCTL_EVT_ID_VALUE);
		br(8'h0c);
		chk(rd, t1);
		stop_test();
	end
endmodule : test_control_features_tb
